// ### src/pcic_consts.svh
// register offsets, field positions, codes and reset values
`ifndef PCIC_CONSTS_SVH
`define PCIC_CONSTS_SVH
// ==========================================================
// register byte offsets
`define PCIC_OFF_CTRL   6'h00
`define PCIC_OFF_HDR    6'h04
`define PCIC_OFF_DATA   6'h08
`define PCIC_OFF_STAT   6'h0c
`define PCIC_OFF_RESP   6'h10
`define PCIC_OFF_CFG    6'h14
`define PCIC_OFF_PINREF 6'h18
`define PCIC_OFF_RECWR  6'h1c
// ==========================================================
// field positions
`define PCIC_CTRL_START   0
`define PCIC_CTRL_SESSION 1
`define PCIC_CFG_FILESEL  0
`define PCIC_CFG_AMINCR   1
`define PCIC_CFG_INCRPIN  2
`define PCIC_CFG_INCRSLOT 3
`define PCIC_CFG_DIS0     4
`define PCIC_CFG_RECLEN   12:6
`define PCIC_CFG_SFI      17:13
`define PCIC_RECWR_CUR    18
// ==========================================================
// instruction codes and status words
`define PCIC_INS_INCR   8'h32
`define PCIC_INS_VERIFY 8'h20
`define PCIC_INS_CHANGE 8'h24
`define PCIC_SW_OK      16'h9000
`define PCIC_SW_TRIES   12'h63c
`define PCIC_SW_BLOCKED 16'h6983
`define PCIC_SW_DISABLE 16'h6984
`define PCIC_SW_SEC     16'h6982
`define PCIC_SW_P1P2    16'h6b00
`define PCIC_SW_LEN     16'h6700
`define PCIC_SW_NOFILE  16'h6a82
`define PCIC_SW_NOREF   16'h6a88
`define PCIC_SW_OVF     16'h6a84
`define PCIC_SW_INS     16'h6d00
// ==========================================================
// sizes and reset values
`define PCIC_NPIN       2
`define PCIC_NREC       4
`define PCIC_TRIES_INIT 2'h3
`define PCIC_PIN_LEN    8'h08
`define PCIC_CHG_LEN    8'h10
`define PCIC_PIN_RESET  64'h31323334ffffffff
`define PCIC_CFG_RESET  18'h00040
`define PCIC_REF_RESET  16'h8101
`endif

// ### src/pcic_pkg.sv
// types shared by the command block
`default_nettype none
package pcic_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ADD  = 3'b010,
		ST_COPY = 3'b100
	} pcic_state_type;
endpackage
`default_nettype wire

// ### src/pcic_pin_if.sv
// carrier between command core and one pin slot
`timescale 1ns/100ps
`default_nettype none
interface pcic_pin_if;
	logic        do_check;
	logic        do_change;
	logic        clr_session;
	logic        disabled;
	logic [63:0] cand;
	logic [63:0] newv;
	logic        match;
	logic [1:0]  tries;
	logic        verified;
	modport ctl  (output do_check, do_change, clr_session, disabled, cand, newv, input match, tries, verified);
	modport slot (input do_check, do_change, clr_session, disabled, cand, newv, output match, tries, verified);
endinterface
`default_nettype wire

// ### src/pcic_pin_slot.sv
// one pin: reference value, retry counter, verified state
`timescale 1ns/100ps
`default_nettype none
module pcic_pin_slot
	import pcic_pkg::*;
(
	input  wire logic   i_ref_clk,
	input  wire logic   i_reset,
	pcic_pin_if.slot    p
);
`include "pcic_consts.svh"
	logic [1:0]  tries_reg, tries_next;
	logic [63:0] pin_reg, pin_next;
	logic        ver_reg, ver_next;

	assign p.match    = (p.cand == pin_reg);
	assign p.tries    = tries_reg;
	assign p.verified = ver_reg;

	// ==========================================================
	// compare and counter update
	always_comb begin
		tries_next = tries_reg;
		pin_next   = pin_reg;
		ver_next   = ver_reg & ~p.clr_session;
		if (p.do_check && !p.disabled && tries_reg != 2'h0) begin // [RULE_08]
			if (p.match) begin
				tries_next = `PCIC_TRIES_INIT; // [RULE_09] [RULE_19]
				ver_next   = 1'b1; // [RULE_07]
				if (p.do_change)
					pin_next = p.newv; // [RULE_18] [RULE_19]
			end else begin
				tries_next = tries_reg - 2'h1; // [RULE_10] [RULE_20]
				ver_next   = 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			tries_reg <= `PCIC_TRIES_INIT;
			pin_reg   <= `PCIC_PIN_RESET;
			ver_reg   <= 1'b0;
		end else begin
			tries_reg <= tries_next;
			pin_reg   <= pin_next;
			ver_reg   <= ver_next;
		end
	end
endmodule
`default_nettype wire

// ### src/pcic_core.sv
// pin check and increase command core with avalon-mm slave
// Behaviour
// [RULE_01] increase adds value to newest record, stores into oldest, makes it record 1
// [RULE_02] increase allowed only if access object grants instruction 32 and is satisfied
// [RULE_03] sum carrying past all-ff record is refused, records unchanged
// [RULE_04] increase needs p2 zero; p1 zero or 100 plus short file identifier
// [RULE_05] increase length between 1 and 127, not above record length
// [RULE_06] increase answers new record then the added bytes
// [RULE_07] verified state is shared by all logical channels
// [RULE_08] compare only when pin neither disabled nor blocked
// [RULE_09] matching verify restores retry counter to 3
// [RULE_10] wrong pin decrements counter, answers 63c2, 63c1, then blocks with 63c0
// [RULE_11] verify with data on blocked pin answers 6983
// [RULE_12] blocked pin never grants access until unblocked
// [RULE_13] pin-guarded operation allowed only after verify unless pin disabled
// [RULE_14] empty verify compares nothing, answers 63cx even if disabled or blocked
// [RULE_15] empty verify on blocked pin answers 63c0
// [RULE_16] verify uses p1 zero and length zero or eight
// [RULE_17] p2 bits 7:6 zero, reference 01 to 1f, zero unsupported; code checks only p2 bits 6:5 for zero, bit 7 may be set
// [RULE_18] change only on enabled unblocked pin; new value used at once everywhere
// [RULE_19] change with matching old pin restores counter and installs new pin
// [RULE_20] change with wrong old pin decrements counter, blocks after three
// [RULE_21] change uses p1 zero and length sixteen, old then new pin
// [RULE_22] reserved p1, p2 or length gives error, nothing changes
`timescale 1ns/100ps
`default_nettype none
module pcic_core
	import pcic_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);
`include "pcic_consts.svh"
	// ==========================================================
	// state
	pcic_state_type state_reg, state_next;
	logic        ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] hdr_reg, hdr_next;
	logic [17:0] cfg_reg, cfg_next;
	logic [15:0] ref_reg, ref_next;
	logic [7:0]  widx_reg, widx_next;
	logic [7:0]  ridx_reg, ridx_next;
	logic [7:0]  rlen_reg, rlen_next;
	logic [15:0] sw_reg, sw_next;
	logic [6:0]  pos_reg, pos_next;
	logic        carry_reg, carry_next;
	logic [1:0]  cur_reg, cur_next;
	logic [7:0]  cmd_mem [0:127];
	logic [7:0]  resp_mem [0:255];
	logic [7:0]  rec_mem [0:511];

	// ==========================================================
	// bus decode
	logic       acc, wacc, racc, start, sess;
	logic [7:0] ins, p1, p2, lc;
	logic [6:0] reclen;
	assign acc   = (i_avs_read | i_avs_write) & ack_reg;
	assign wacc  = i_avs_write & ack_reg;
	assign racc  = i_avs_read & ack_reg;
	assign start = wacc && i_avs_address == `PCIC_OFF_CTRL && i_avs_writedata[`PCIC_CTRL_START]
		&& state_reg == ST_IDLE;
	assign sess  = wacc && i_avs_address == `PCIC_OFF_CTRL && i_avs_writedata[`PCIC_CTRL_SESSION];
	assign ins    = hdr_reg[7:0];
	assign p1     = hdr_reg[15:8];
	assign p2     = hdr_reg[23:16];
	assign lc     = hdr_reg[31:24];
	assign reclen = cfg_reg[`PCIC_CFG_RECLEN];
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
	assign o_avs_readdata    = rdata_reg;

	// ==========================================================
	// pin slots
	pcic_pin_if pif [`PCIC_NPIN] ();
	logic [1:0]  hit, dis, blk, ver, grant;
	logic [1:0]  tries_s [0:1];
	logic [1:0]  do_chk;
	logic        do_chg, sel, match_s;
	logic [63:0] cand, newv;
	genvar k;
	generate
		for (k = 0; k < `PCIC_NPIN; k++) begin : g_slot
			assign pif[k].do_check    = do_chk[k];
			assign pif[k].do_change   = do_chg;
			assign pif[k].clr_session = sess;
			assign pif[k].disabled    = dis[k];
			assign pif[k].cand        = cand;
			assign pif[k].newv        = newv;
			assign hit[k]     = (p2 == ref_reg[8*k +: 8]);
			assign dis[k]     = cfg_reg[`PCIC_CFG_DIS0 + k];
			assign tries_s[k] = pif[k].tries;
			assign blk[k]     = (pif[k].tries == 2'h0);
			assign ver[k]     = pif[k].verified;
			assign grant[k]   = ~blk[k] & (dis[k] | ver[k]); // [RULE_12] [RULE_13]
			pcic_pin_slot u_slot (
				.i_ref_clk (i_ref_clk),
				.i_reset   (i_reset),
				.p         (pif[k])
			);
		end
	endgenerate
	assign sel     = hit[1];
	assign match_s = sel ? pif[1].match : pif[0].match;

	always_comb begin
		for (int j = 0; j < 8; j++) begin
			cand[63 - 8*j -: 8] = cmd_mem[j];
			newv[63 - 8*j -: 8] = cmd_mem[j + 8]; // [RULE_21]
		end
	end

	// ==========================================================
	// adder datapath
	logic [6:0] off, bidx;
	logic [8:0] addr_cur, addr_old;
	logic [7:0] abyte, bbyte;
	logic [8:0] sum;
	assign off      = reclen - 7'h01 - pos_reg;
	assign bidx     = lc[6:0] - 7'h01 - off;
	assign addr_cur = {cur_reg, pos_reg};
	assign addr_old = {cur_reg + 2'h1, pos_reg};
	assign abyte    = rec_mem[addr_cur];
	assign bbyte    = (off < lc[6:0]) ? cmd_mem[bidx] : 8'h00;
	assign sum      = {1'b0, abyte} + {1'b0, bbyte} + {8'h00, carry_reg};

	// ==========================================================
	// command sequencing
	logic       sfi_ok, p2_ok, lens_ok;
	logic [1:0] t_sel;
	always_comb begin
		state_next = state_reg;
		sw_next    = sw_reg;
		rlen_next  = rlen_reg;
		pos_next   = pos_reg;
		carry_next = carry_reg;
		cur_next   = cur_reg;
		do_chk     = 2'b00;
		do_chg     = 1'b0;
		t_sel      = tries_s[sel];
		sfi_ok     = (p1 == 8'h00) ? cfg_reg[`PCIC_CFG_FILESEL] : (p1[4:0] == cfg_reg[`PCIC_CFG_SFI]);
		p2_ok      = p2[6:5] == 2'b00 && p2[4:0] != 5'h00 && hit != 2'b00; // [RULE_17]
		lens_ok    = widx_reg == lc;
		if (wacc && i_avs_address == `PCIC_OFF_RECWR && state_reg == ST_IDLE
			&& i_avs_writedata[`PCIC_RECWR_CUR])
			cur_next = i_avs_writedata[17:16];
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					rlen_next = 8'h00;
					if (ins == `PCIC_INS_INCR) begin
						if (p2 != 8'h00 || !(p1 == 8'h00 || p1[7:5] == 3'b100)) begin
							sw_next = `PCIC_SW_P1P2; // [RULE_04] [RULE_22]
						end else if (lc == 8'h00 || lc[7] || lc[6:0] > reclen || !lens_ok) begin
							sw_next = `PCIC_SW_LEN; // [RULE_05] [RULE_22]
						end else if (!sfi_ok) begin
							sw_next = `PCIC_SW_NOFILE; // [RULE_04]
						end else if (!cfg_reg[`PCIC_CFG_AMINCR]
							|| (cfg_reg[`PCIC_CFG_INCRPIN] && !grant[cfg_reg[`PCIC_CFG_INCRSLOT]])) begin
							sw_next = `PCIC_SW_SEC; // [RULE_02] [RULE_13]
						end else begin
							pos_next   = reclen - 7'h01;
							carry_next = 1'b0;
							state_next = ST_ADD;
						end
					end else if (ins == `PCIC_INS_VERIFY || ins == `PCIC_INS_CHANGE) begin
						if (p1 != 8'h00 || !p2_ok) begin
							sw_next = (p1 != 8'h00 || p2[6:5] != 2'b00 || p2[4:0] == 5'h00)
								? `PCIC_SW_P1P2 : `PCIC_SW_NOREF; // [RULE_16] [RULE_17] [RULE_22]
						end else if (ins == `PCIC_INS_VERIFY && lc == 8'h00) begin
							sw_next = {`PCIC_SW_TRIES, 2'b00, t_sel}; // [RULE_14] [RULE_15]
						end else if (lc != (ins == `PCIC_INS_VERIFY ? `PCIC_PIN_LEN : `PCIC_CHG_LEN)
							|| !lens_ok) begin
							sw_next = `PCIC_SW_LEN; // [RULE_16] [RULE_21] [RULE_22]
						end else if (blk[sel]) begin
							sw_next = `PCIC_SW_BLOCKED; // [RULE_11] [RULE_18]
						end else if (dis[sel]) begin
							sw_next = `PCIC_SW_DISABLE; // [RULE_08] [RULE_18]
						end else begin
							do_chk[sel] = 1'b1; // [RULE_08]
							do_chg      = (ins == `PCIC_INS_CHANGE); // [RULE_18]
							sw_next     = match_s ? `PCIC_SW_OK
								: {`PCIC_SW_TRIES, 2'b00, t_sel - 2'h1}; // [RULE_10] [RULE_20]
						end
					end else begin
						sw_next = `PCIC_SW_INS;
					end
				end
			end
			ST_ADD: begin
				carry_next = sum[8];
				pos_next   = pos_reg - 7'h01;
				if (pos_reg == 7'h00) begin
					pos_next = 7'h00;
					if (sum[8]) begin
						sw_next    = `PCIC_SW_OVF; // [RULE_03]
						state_next = ST_IDLE;
					end else begin
						state_next = ST_COPY;
					end
				end
			end
			ST_COPY: begin
				pos_next = pos_reg + 7'h01;
				if (pos_reg == reclen - 7'h01) begin
					cur_next   = cur_reg + 2'h1; // [RULE_01]
					rlen_next  = {1'b0, reclen} + lc; // [RULE_06]
					sw_next    = `PCIC_SW_OK;
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// ==========================================================
	// register writes and read data
	always_comb begin
		ack_next   = (i_avs_read | i_avs_write) & ~ack_reg;
		rdata_next = rdata_reg;
		hdr_next   = hdr_reg;
		cfg_next   = cfg_reg;
		ref_next   = ref_reg;
		widx_next  = start ? 8'h00 : widx_reg;
		ridx_next  = start ? 8'h00 : ridx_reg;
		if (wacc && state_reg == ST_IDLE) begin
			if (i_avs_address == `PCIC_OFF_HDR)
				hdr_next = i_avs_writedata;
			else if (i_avs_address == `PCIC_OFF_DATA && widx_reg != 8'h80)
				widx_next = widx_reg + 8'h01;
			else if (i_avs_address == `PCIC_OFF_CFG)
				cfg_next = i_avs_writedata[17:0];
			else if (i_avs_address == `PCIC_OFF_PINREF)
				ref_next = i_avs_writedata[15:0];
		end
		if (racc && i_avs_address == `PCIC_OFF_RESP && ridx_reg < rlen_reg)
			ridx_next = ridx_reg + 8'h01;
		if (i_avs_read && !ack_reg) begin
			if (i_avs_address == `PCIC_OFF_HDR)
				rdata_next = hdr_reg;
			else if (i_avs_address == `PCIC_OFF_STAT)
				rdata_next = {rlen_reg, 1'b0, ver, blk, grant, state_reg != ST_IDLE, sw_reg};
			else if (i_avs_address == `PCIC_OFF_RESP)
				rdata_next = {24'h000000, (ridx_reg < rlen_reg) ? resp_mem[ridx_reg] : 8'h00};
			else if (i_avs_address == `PCIC_OFF_CFG)
				rdata_next = {14'h0000, cfg_reg};
			else if (i_avs_address == `PCIC_OFF_PINREF)
				rdata_next = {16'h0000, ref_reg};
			else
				rdata_next = 32'h00000000;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= ST_IDLE;
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h00000000;
			hdr_reg   <= 32'h00000000;
			cfg_reg   <= `PCIC_CFG_RESET;
			ref_reg   <= `PCIC_REF_RESET;
			widx_reg  <= 8'h00;
			ridx_reg  <= 8'h00;
			rlen_reg  <= 8'h00;
			sw_reg    <= 16'h0000;
			pos_reg   <= 7'h00;
			carry_reg <= 1'b0;
			cur_reg   <= 2'h0;
		end else begin
			state_reg <= state_next;
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
			hdr_reg   <= hdr_next;
			cfg_reg   <= cfg_next;
			ref_reg   <= ref_next;
			widx_reg  <= widx_next;
			ridx_reg  <= ridx_next;
			rlen_reg  <= rlen_next;
			sw_reg    <= sw_next;
			pos_reg   <= pos_next;
			carry_reg <= carry_next;
			cur_reg   <= cur_next;
		end
	end

	// ==========================================================
	// memories
	always_ff @(posedge i_ref_clk) begin
		if (wacc && state_reg == ST_IDLE && i_avs_address == `PCIC_OFF_DATA && widx_reg != 8'h80)
			cmd_mem[widx_reg[6:0]] <= i_avs_writedata[7:0];
		if (state_reg == ST_ADD)
			resp_mem[{1'b0, pos_reg}] <= sum[7:0]; // [RULE_06]
		else if (state_reg == ST_COPY && pos_reg < lc[6:0])
			resp_mem[{1'b0, reclen} + {1'b0, pos_reg}] <= cmd_mem[pos_reg]; // [RULE_06]
		if (state_reg == ST_COPY)
			rec_mem[addr_old] <= resp_mem[{1'b0, pos_reg}]; // [RULE_01]
		else if (wacc && state_reg == ST_IDLE && i_avs_address == `PCIC_OFF_RECWR)
			rec_mem[{i_avs_writedata[17:16], i_avs_writedata[14:8]}] <= i_avs_writedata[7:0];
	end
endmodule
`default_nettype wire

// ### sim/pcic_core_assertions.sv
// bus and status checker for the command core
`timescale 1ns/100ps
`default_nettype none
`include "pcic_consts.svh"
module pcic_core_assertions
	import pcic_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest
);
	// ==========================================================
	// last header and start seen
	logic [31:0] hdr_reg, hdr_next;
	logic        go_reg, go_next;
	logic        acc, rd_stat, stat_rd;
	assign acc = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
	assign rd_stat = acc & i_avs_read & (i_avs_address == `PCIC_OFF_STAT);
	assign stat_rd = rd_stat & go_reg;
	always_comb begin
		hdr_next = hdr_reg;
		go_next = go_reg;
		if (acc && i_avs_write && i_avs_address == `PCIC_OFF_HDR) begin
			hdr_next = i_avs_writedata;
			go_next = 1'b0;
		end
		if (acc && i_avs_write && i_avs_address == `PCIC_OFF_CTRL && i_avs_writedata[0]) begin
			go_next = 1'b1;
		end
	end
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			hdr_reg <= 32'h0;
			go_reg <= 1'b0;
		end else begin
			hdr_reg <= hdr_next;
			go_reg <= go_next;
		end
	end
	// ==========================================================
	// properties
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	property p_one_wait;
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
	property p_idle_free;
		!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
	endproperty
	a_idle_free: assert property (p_idle_free) else $error("wait without request");
	property p_unmapped_zero;
		acc && i_avs_read && i_avs_address >= 6'h20 |-> o_avs_readdata == 32'h0;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	property p_block_denies;
		rd_stat |-> !(o_avs_readdata[19] && o_avs_readdata[17]) && !(o_avs_readdata[20] && o_avs_readdata[18]);
	endproperty
	a_block_denies: assert property (p_block_denies) else $error("blocked pin grants");
	property p_verified_grants;
		rd_stat && o_avs_readdata[22] && !o_avs_readdata[20] |-> o_avs_readdata[18];
	endproperty
	a_verified_grants: assert property (p_verified_grants) else $error("verified pin not granted");
	property p_tries_range;
		rd_stat && o_avs_readdata[15:4] == `PCIC_SW_TRIES |-> o_avs_readdata[3:0] <= 4'h3;
	endproperty
	a_tries_range: assert property (p_tries_range) else $error("retry count above three");
	property p_verify_p1;
		stat_rd && hdr_reg[7:0] == `PCIC_INS_VERIFY && hdr_reg[15:8] != 8'h0 |-> o_avs_readdata[15:0] == `PCIC_SW_P1P2;
	endproperty
	a_verify_p1: assert property (p_verify_p1) else $error("verify with bad p1 accepted");
	property p_change_len;
		stat_rd && hdr_reg[15:0] == {8'h0, `PCIC_INS_CHANGE} && hdr_reg[23:16] == 8'h81 && hdr_reg[31:24] != `PCIC_CHG_LEN
			|-> o_avs_readdata[15:0] == `PCIC_SW_LEN;
	endproperty
	a_change_len: assert property (p_change_len) else $error("change with bad length accepted");
	property p_incr_p2;
		stat_rd && hdr_reg[7:0] == `PCIC_INS_INCR && hdr_reg[23:16] != 8'h0 && !o_avs_readdata[16]
			|-> o_avs_readdata[15:0] == `PCIC_SW_P1P2;
	endproperty
	a_incr_p2: assert property (p_incr_p2) else $error("increase with bad p2 accepted");
	property p_pin_done;
		stat_rd && hdr_reg[7:0] != `PCIC_INS_INCR |-> !o_avs_readdata[16];
	endproperty
	a_pin_done: assert property (p_pin_done) else $error("pin command still busy");
	c_blocked: cover property (stat_rd && o_avs_readdata[15:0] == `PCIC_SW_BLOCKED);
	c_resp: cover property (acc && i_avs_address == `PCIC_OFF_RESP);
	c_incr_busy: cover property (stat_rd && o_avs_readdata[16]);
endmodule
bind pcic_core pcic_core_assertions u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

// ### sim/pcic_term_model.sv
// terminal model: avalon master sending command headers and data
`timescale 1ns/100ps
`default_nettype none
`include "pcic_consts.svh"
module pcic_term_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_avs_waitrequest,
	input  wire logic [31:0] i_avs_readdata,
	output logic [5:0]       o_avs_address,
	output logic             o_avs_read,
	output logic             o_avs_write,
	output logic [31:0]      o_avs_writedata
);
	initial begin
		o_avs_address = 6'h00;
		o_avs_read = 1'b0;
		o_avs_write = 1'b0;
		o_avs_writedata = 32'h0;
	end
	// ==========================================================
	// one bus access, held until waitrequest low
	task automatic bus_acc(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_ref_clk);
		o_avs_address <= a;
		o_avs_writedata <= d;
		o_avs_write <= wr;
		o_avs_read <= !wr;
		@(posedge i_ref_clk);
		while (i_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
		q = i_avs_readdata;
		o_avs_write <= 1'b0;
		o_avs_read <= 1'b0;
		o_avs_writedata <= ~d;
	endtask
	// ==========================================================
	// header {lc, p2, p1, ins}, data bytes first at msb, wait for done
	task automatic send_cmd(input logic [31:0] hdr, input logic [127:0] dat, output logic [15:0] sw);
		logic [31:0] q;
		bus_acc(1'b1, `PCIC_OFF_HDR, hdr, q);
		for (int i = 0; i < int'(hdr[31:24]); i++) bus_acc(1'b1, `PCIC_OFF_DATA, {24'h0, dat[127-8*i -: 8]}, q);
		bus_acc(1'b1, `PCIC_OFF_CTRL, 32'h1, q);
		q = 32'h00010000;
		for (int n = 0; n < 400 && q[16] !== 1'b0; n++) bus_acc(1'b0, `PCIC_OFF_STAT, 32'h0, q);
		sw = q[15:0];
	endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// top testbench: command sequences through the terminal model
`timescale 1ns/100ps
`default_nettype none
`include "pcic_consts.svh"
module tb_top;
	logic        i_ref_clk;
	logic        i_reset;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          bad_count;
	int          total_checks;
	int          cycles;
	localparam logic [127:0] GOOD = {`PCIC_PIN_RESET, 64'h0};
	localparam logic [63:0]  NEWP = 64'h0102030405060708;
	pcic_core DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_avs_address(avs_address), .i_avs_read(avs_read),
		.i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest));
	pcic_term_model term (.i_ref_clk(i_ref_clk), .i_avs_waitrequest(avs_waitrequest), .i_avs_readdata(avs_readdata),
		.o_avs_address(avs_address), .o_avs_read(avs_read), .o_avs_write(avs_write), .o_avs_writedata(avs_writedata));
	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cmd(input logic [31:0] hdr, input logic [127:0] d, input logic [15:0] exp);
		logic [15:0] sw;
		term.send_cmd(hdr, d, sw);
		check("status word", {16'h0, sw}, {16'h0, exp});
	endtask
	task automatic rreg(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		term.bus_acc(1'b0, a, 32'h0, q);
		check("register", q, exp);
	endtask
	task automatic wreg(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		term.bus_acc(1'b1, a, d, q);
	endtask
	task automatic stat(input logic [5:0] exp);
		logic [31:0] q;
		term.bus_acc(1'b0, `PCIC_OFF_STAT, 32'h0, q);
		check("pin state", {26'h0, q[22:17]}, {26'h0, exp});
	endtask
	task automatic resp3(input logic [23:0] e);
		for (int k = 0; k < 3; k++) rreg(`PCIC_OFF_RESP, {24'h0, e[23-8*k -: 8]});
	endtask
	// ==========================================================
	// clock, reset, timeout
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			complete_run();
		end
	end
	// ==========================================================
	// tests
	initial begin
		i_reset = 1'b1;
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		repeat (8) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		rreg(`PCIC_OFF_CFG, {14'h0, `PCIC_CFG_RESET});
		rreg(`PCIC_OFF_PINREF, {16'h0, `PCIC_REF_RESET});
		rreg(6'h3c, 32'h0);
		cmd(32'h00010020, 128'h0, {`PCIC_SW_TRIES, 4'h3});
		for (int i = 0; i < 3; i++) cmd(32'h08010020, 128'h0, {`PCIC_SW_TRIES, 4'(2 - i)});
		cmd(32'h08010020, GOOD, `PCIC_SW_BLOCKED);
		cmd(32'h00010020, 128'h0, {`PCIC_SW_TRIES, 4'h0});
		stat(6'b000100);
		cmd(32'h10810024, {64'h0, NEWP}, {`PCIC_SW_TRIES, 4'h2});
		cmd(32'h08810020, GOOD, `PCIC_SW_OK);
		cmd(32'h00810020, 128'h0, {`PCIC_SW_TRIES, 4'h3});
		stat(6'b100110);
		cmd(32'h10810024, {`PCIC_PIN_RESET, NEWP}, `PCIC_SW_OK);
		cmd(32'h08810020, GOOD, {`PCIC_SW_TRIES, 4'h2});
		cmd(32'h08810020, {NEWP, 64'h0}, `PCIC_SW_OK);
		wreg(`PCIC_OFF_CTRL, 32'h2);
		stat(6'b000100);
		cmd(32'h00010020, 128'h0, {`PCIC_SW_TRIES, 4'h0});
		cmd(32'h08810120, 128'h0, `PCIC_SW_P1P2);
		cmd(32'h08c10020, 128'h0, `PCIC_SW_P1P2);
		cmd(32'h05810020, 128'h0, `PCIC_SW_LEN);
		cmd(32'h08810024, 128'h0, `PCIC_SW_LEN);
		cmd(32'h00810020, 128'h0, {`PCIC_SW_TRIES, 4'h3});
		wreg(`PCIC_OFF_CFG, 32'h83);
		wreg(`PCIC_OFF_RECWR, 32'h00040000);
		wreg(`PCIC_OFF_RECWR, 32'h00040110);
		cmd(32'h01000032, {8'h05, 120'h0}, `PCIC_SW_OK);
		resp3(24'h001505);
		cmd(32'h01000032, {8'h01, 120'h0}, `PCIC_SW_OK);
		resp3(24'h001601);
		cmd(32'h02000032, {16'hffff, 112'h0}, `PCIC_SW_OVF);
		cmd(32'h03000032, 128'h0, `PCIC_SW_LEN);
		cmd(32'h00000032, 128'h0, `PCIC_SW_LEN);
		cmd(32'h01004032, 128'h0, `PCIC_SW_P1P2);
		cmd(32'h01010032, 128'h0, `PCIC_SW_P1P2);
		wreg(`PCIC_OFF_CFG, 32'h81);
		cmd(32'h01000032, {8'h01, 120'h0}, `PCIC_SW_SEC);
		wreg(`PCIC_OFF_CFG, 32'h83);
		cmd(32'h01000032, {8'h01, 120'h0}, `PCIC_SW_OK);
		resp3(24'h001701);
		// pin-guarded increase, then slot1 disabled
		wreg(`PCIC_OFF_CFG, 32'h8f);
		cmd(32'h01000032, {8'h01, 120'h0}, `PCIC_SW_SEC);
		wreg(`PCIC_OFF_CFG, 32'haf);
		cmd(32'h01000032, {8'h01, 120'h0}, `PCIC_SW_OK);
		resp3(24'h001801);
		cmd(32'h08810020, {NEWP, 64'h0}, `PCIC_SW_DISABLE);
		cmd(32'h10810024, {NEWP, NEWP}, `PCIC_SW_DISABLE);
		cmd(32'h00810020, 128'h0, {`PCIC_SW_TRIES, 4'h3});
		stat(6'b000110);
		complete_run();
	end
endmodule
`default_nettype wire
